/* File: pkg/etf_pkg.sv */
package etf_pkg;
  // register port
  localparam int ETF_AW = 8;
  localparam int ETF_DW = 8;
  localparam logic [7:0] ETF_OFS_EDGE = 8'hbf;
  localparam logic [7:0] ETF_OFS_IRQ_EN = 8'hc0;
  localparam logic [7:0] ETF_OFS_IRQ_FLAG = 8'hc1;
  localparam logic [7:0] ETF_OFS_CTRL = 8'hc2;
  localparam logic [7:0] ETF_OFS_EVT_STAT = 8'hc3;
  localparam logic [7:0] ETF_OFS_EVT_MASK = 8'hc4;
  localparam logic [7:0] ETF_OFS_STATE = 8'hc5;
  // request sources, bit positions in enable and flag registers
  localparam int ETF_NSRC = 5;
  localparam int ETF_SRC_EXT = 0;
  localparam int ETF_SRC_T0 = 1;
  localparam int ETF_SRC_T1 = 2;
  localparam int ETF_SRC_T2 = 3;
  localparam int ETF_SRC_PWM = 4;
  localparam int ETF_NTMR = 4;
  // control register field
  localparam int ETF_CTRL_GIE = 7;
  // event status bits
  localparam int ETF_NEVT = 3;
  localparam int ETF_EVT_VEC = 0;
  localparam int ETF_EVT_WAKE = 1;
  localparam int ETF_EVT_RET = 2;
  // reset values
  localparam logic [1:0] ETF_EDGE_RST = 2'h0;
  localparam logic [4:0] ETF_EN_RST = 5'h00;
  localparam logic [2:0] ETF_MASK_RST = 3'h0;
  // program counter and vector
  localparam int ETF_PC_W = 12;
  localparam logic [11:0] ETF_VECTOR_ADDR = 12'h008;
  // synchroniser arm delay in cycles
  localparam int ETF_ARM_LEN = 3;

  typedef enum logic [1:0] {
    ETF_EDGE_RSVD = 2'b00,
    ETF_EDGE_RISE = 2'b01,
    ETF_EDGE_FALL = 2'b10,
    ETF_EDGE_BOTH = 2'b11
  } etf_edge_t;

  typedef enum logic {
    ETF_SVC_IDLE = 1'b0,
    ETF_SVC_BUSY = 1'b1
  } etf_svc_t;

  typedef struct packed {
    logic [7:0] work_register;
    logic [7:0] status_flags;
  } etf_ctx_t;
endpackage : etf_pkg

/* File: src/etf_edge_det.sv */
`timescale 1ns/1ps
`default_nettype none
module etf_edge_det (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // pin and selection
  input wire logic pin_i,
  input wire etf_pkg::etf_edge_t sel_i,
  // detected edges, one-cycle pulses
  output logic rise_o,
  output logic fall_o,
  output logic hit_o
);
  import etf_pkg::*;
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic [ETF_ARM_LEN-1:0] arm_q;
  logic armed;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      arm_q <= '0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      arm_q <= {arm_q[ETF_ARM_LEN-2:0], 1'b1};
    end
  end
  // no edge until the chain holds real pin samples
  assign armed = arm_q[ETF_ARM_LEN-1];
  // R16 compare samples
  assign rise_o = armed && sync2_q && !prev_q;
  assign fall_o = armed && !sync2_q && prev_q;
  // R1 edge select decode
  assign hit_o = (sel_i == ETF_EDGE_RISE) ? rise_o :
                 (sel_i == ETF_EDGE_FALL) ? fall_o :
                 (sel_i == ETF_EDGE_BOTH) ? (rise_o | fall_o) : 1'b0;

  // R16 edge from samples
  chk_edge_compare: assert property (@(posedge core_clk_i) disable iff (rst_i) // R16
    (rise_o | fall_o) |-> (sync2_q != $past(sync2_q)))
    else $error("edge reported without a sample change");
endmodule : etf_edge_det
`default_nettype wire

/* File: src/etf_irq_ctrl.sv */
// Notes on behaviour
// R1 - The edge select field picks rising (01), falling (10) or both (11) edges; 00 picks none.
// R2 - The external flag sets on a selected pin edge only while its enable bit is one.
// R3 - An enabled external edge loads the program counter with vector address 8.
// R4 - A selected pin edge during power-down is latched, wakes the core and is served first.
// R5 - A timer 0 overflow sets the timer 0 flag whatever its enable bit holds.
// R6 - Timer 0 overflow vectors only when its enable bit is one; the flag sets anyway.
// R7 - Timer 1 overflow sets its flag always and vectors only when enabled.
// R8 - Timer 2 overflow sets its flag always and vectors only when enabled.
// R9 - The pwm timer overflow sets its flag always and vectors only when enabled.
// R10 - A flag set while its source was disabled never vectors when enabled later.
// R11 - Software clears a request flag by writing zero to it.
// R12 - Software loads the same start count into a reloading timer and its reload buffer.
// R13 - Vectoring needs the global enable, which is cleared on entry and set by return.
// R14 - Work register and status flags are saved in one buffer on entry, restored on return.
// R15 - Request flags stay set after their event until software clears them.
// R16 - The pin is synchronised and edges come from comparing two successive samples.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module etf_irq_ctrl (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [etf_pkg::ETF_AW-1:0] reg_addr_i,
  input wire logic [etf_pkg::ETF_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [etf_pkg::ETF_DW-1:0] reg_rdata_o,
  // external pin and power state
  input wire logic ext_pin_irq_i,
  input wire logic power_down_i,
  output logic wake_o,
  // timer overflow pulses: t0, t1, t2, pwm
  input wire logic [etf_pkg::ETF_NTMR-1:0] tmr_ovf_i,
  // processor core
  input wire etf_pkg::etf_ctx_t ctx_i,
  input wire logic return_from_irq_i,
  output logic vec_load_o,
  output logic [etf_pkg::ETF_PC_W-1:0] vec_addr_o,
  output etf_pkg::etf_ctx_t ctx_o,
  output logic ctx_restore_o,
  output logic global_irq_enable_o,
  // system interrupt
  output logic irq_o
);
  import etf_pkg::*;

  logic [1:0] ext_edge_sel_q;
  logic [ETF_NSRC-1:0] irq_en_q;
  logic [ETF_NEVT-1:0] evt_mask_q;
  logic [ETF_NSRC-1:0] pend_q;
  logic [ETF_NSRC-1:0] pend_d;
  logic [ETF_NSRC-1:0] flag;
  logic [ETF_NEVT-1:0] evt_stat;
  logic [ETF_NEVT-1:0] evt_set;
  logic global_irq_enable_q;
  logic wake_q;
  logic vec_load_q;
  logic ctx_restore_q;
  logic buf_valid_q;
  etf_ctx_t ctx_buf_q;
  etf_ctx_t ctx_out_q;
  etf_svc_t svc_q;
  etf_svc_t svc_d;
  logic [ETF_DW-1:0] rdata_q;
  logic [ETF_DW-1:0] rdata_d;
  logic ext_hit;
  logic [ETF_NSRC-1:0] src_evt;
  logic [ETF_NSRC-1:0] flag_clr;
  logic wr_edge;
  logic wr_en;
  logic wr_flag;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic take;
  logic wake_set;

  // one port access aimed at one register offset
  function automatic logic reg_hit(input logic [ETF_AW-1:0] addr,
                                   input logic [ETF_AW-1:0] ofs);
    return addr == ofs;
  endfunction : reg_hit

  // register decode
  assign wr_edge = reg_we_i && reg_hit(reg_addr_i, ETF_OFS_EDGE);
  assign wr_en = reg_we_i && reg_hit(reg_addr_i, ETF_OFS_IRQ_EN);
  assign wr_flag = reg_we_i && reg_hit(reg_addr_i, ETF_OFS_IRQ_FLAG);
  assign wr_ctrl = reg_we_i && reg_hit(reg_addr_i, ETF_OFS_CTRL);
  assign wr_stat = reg_we_i && reg_hit(reg_addr_i, ETF_OFS_EVT_STAT);
  assign wr_mask = reg_we_i && reg_hit(reg_addr_i, ETF_OFS_EVT_MASK);

  // R16 pin synchroniser and edge compare
  etf_edge_det u_edge (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i(ext_pin_irq_i),
    .sel_i(etf_edge_t'(ext_edge_sel_q)),
    .rise_o(),
    .fall_o(),
    .hit_o(ext_hit)
  );

  // R2 external request gated by enable
  assign src_evt[ETF_SRC_EXT] = ext_hit && irq_en_q[ETF_SRC_EXT];
  // R5 R7 R8 R9 timer flags set regardless of enable
  assign src_evt[ETF_SRC_PWM:ETF_SRC_T0] = tmr_ovf_i;

  // R11 a written zero clears a flag
  assign flag_clr = wr_flag ? ~reg_wdata_i[ETF_NSRC-1:0] : '0;

  // R15 sticky request flags, and sticky event status bits cleared by a written one
  genvar gi;
  generate
    for (gi = 0; gi < ETF_NSRC; gi++) begin : g_flag
      etf_sticky #(.CLR_VAL(1'b0)) u_flag (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .set_i(src_evt[gi]),
        .wr_i(wr_flag),
        .wbit_i(reg_wdata_i[gi]),
        .q_o(flag[gi])
      );
    end
    for (gi = 0; gi < ETF_NEVT; gi++) begin : g_evt
      etf_sticky #(.CLR_VAL(1'b1)) u_evt (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .set_i(evt_set[gi]),
        .wr_i(wr_stat),
        .wbit_i(reg_wdata_i[gi]),
        .q_o(evt_stat[gi])
      );
    end
  endgenerate

  // R6 R7 R8 R9 R10 vector only for events enabled when they happened
  assign pend_d = (pend_q & ~flag_clr) | (src_evt & irq_en_q);

  // R13 vector needs global enable, core awake and no service running
  assign take = global_irq_enable_q && !power_down_i && (svc_q == ETF_SVC_IDLE)
                && |(pend_q & flag);

  // R4 wake latch on a selected edge in power-down
  assign wake_set = power_down_i && ext_hit;

  assign evt_set[ETF_EVT_VEC] = take;
  assign evt_set[ETF_EVT_WAKE] = wake_set;
  assign evt_set[ETF_EVT_RET] = return_from_irq_i;

  always_comb begin
    svc_d = svc_q;
    case (svc_q)
      ETF_SVC_IDLE: begin
        if (take) svc_d = ETF_SVC_BUSY;
      end
      ETF_SVC_BUSY: begin
        if (return_from_irq_i) svc_d = ETF_SVC_IDLE;
      end
      default: svc_d = ETF_SVC_IDLE;
    endcase
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = '0;
    case (reg_addr_i)
      ETF_OFS_EDGE: rdata_d = {6'h00, ext_edge_sel_q};
      ETF_OFS_IRQ_EN: rdata_d = {3'h0, irq_en_q};
      ETF_OFS_IRQ_FLAG: rdata_d = {3'h0, flag};
      ETF_OFS_CTRL: rdata_d = {global_irq_enable_q, 7'h00};
      ETF_OFS_EVT_STAT: rdata_d = {5'h00, evt_stat};
      ETF_OFS_EVT_MASK: rdata_d = {5'h00, evt_mask_q};
      ETF_OFS_STATE: rdata_d = {5'h00, buf_valid_q, wake_q, svc_q == ETF_SVC_BUSY};
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ext_edge_sel_q <= ETF_EDGE_RST;
      irq_en_q <= ETF_EN_RST;
      evt_mask_q <= ETF_MASK_RST;
      rdata_q <= '0;
    end else begin
      if (wr_edge) ext_edge_sel_q <= reg_wdata_i[1:0];
      if (wr_en) irq_en_q <= reg_wdata_i[ETF_NSRC-1:0];
      if (wr_mask) evt_mask_q <= reg_wdata_i[ETF_NEVT-1:0];
      rdata_q <= reg_re_i ? rdata_d : '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
      svc_q <= ETF_SVC_IDLE;
      wake_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      svc_q <= svc_d;
      // R4 held until the core leaves power-down
      wake_q <= wake_set | (wake_q & power_down_i);
    end
  end

  // R13 global enable: hardware wins over a software write
  always_ff @(posedge core_clk_i) begin
    if (rst_i) global_irq_enable_q <= 1'b0;
    else if (take) global_irq_enable_q <= 1'b0;
    else if (return_from_irq_i) global_irq_enable_q <= 1'b1;
    else if (wr_ctrl) global_irq_enable_q <= reg_wdata_i[ETF_CTRL_GIE];
  end

  // R14 single level context buffer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctx_buf_q <= '0;
      ctx_out_q <= '0;
      buf_valid_q <= 1'b0;
      ctx_restore_q <= 1'b0;
    end else begin
      ctx_restore_q <= return_from_irq_i && buf_valid_q;
      if (take) begin
        ctx_buf_q <= ctx_i;
        buf_valid_q <= 1'b1;
      end else if (return_from_irq_i) begin
        ctx_out_q <= ctx_buf_q;
        buf_valid_q <= 1'b0;
      end
    end
  end

  // R3 one-cycle vector load
  always_ff @(posedge core_clk_i) begin
    if (rst_i) vec_load_q <= 1'b0;
    else vec_load_q <= take;
  end

  assign vec_load_o = vec_load_q;
  assign vec_addr_o = ETF_VECTOR_ADDR;
  assign ctx_o = ctx_out_q;
  assign ctx_restore_o = ctx_restore_q;
  assign global_irq_enable_o = global_irq_enable_q;
  assign wake_o = wake_q;
  assign reg_rdata_o = rdata_q;
  assign irq_o = |(evt_stat & evt_mask_q);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // R1 reserved select silent
  chk_reserved_no_edge: assert property ( // R1
    (ext_edge_sel_q == ETF_EDGE_RSVD) |-> !ext_hit)
    else $error("reserved edge select produced an edge");
  // R2 flag needs enable
  chk_ext_gated: assert property ( // R2
    $rose(flag[ETF_SRC_EXT]) |-> $past(irq_en_q[ETF_SRC_EXT]))
    else $error("external flag set while disabled");
  // R2 enabled edge flagged
  chk_ext_flag_set: assert property ( // R2
    (ext_hit && irq_en_q[ETF_SRC_EXT]) |=> flag[ETF_SRC_EXT])
    else $error("enabled external edge not flagged");
  // R2 disabled source quiet
  chk_ext_flag_off: assert property ( // R2
    (!irq_en_q[ETF_SRC_EXT] && !flag[ETF_SRC_EXT]) |=> !flag[ETF_SRC_EXT])
    else $error("disabled external source raised its flag");
  // R3 vector load and address
  chk_vector_load: assert property ( // R3
    take |=> vec_load_o && (vec_addr_o == 12'h008) && !global_irq_enable_o)
    else $error("vector not loaded one cycle after take");
  // R3 one cycle load
  chk_vec_pulse: assert property ( // R3
    vec_load_o |=> !vec_load_o)
    else $error("vector load longer than one cycle");
  // R4 wake latched
  chk_wake_latch: assert property ( // R4
    wake_set |=> wake_o && evt_stat[ETF_EVT_WAKE])
    else $error("wake edge not latched");
  // R4 wake held asleep
  chk_wake_hold: assert property ( // R4
    (wake_o && power_down_i) |=> wake_o)
    else $error("wake latch lost during power-down");
  // R4 no vector asleep
  chk_sleep_no_vec: assert property ( // R4
    power_down_i |=> !vec_load_o)
    else $error("vector taken during power-down");
  // R5 timer 0 flag
  chk_t0_flag_set: assert property ( // R5
    tmr_ovf_i[0] |=> flag[ETF_SRC_T0])
    else $error("timer 0 flag missed");
  // R6 timer 0 gate
  chk_t0_vec_gate: assert property ( // R6
    $rose(pend_q[ETF_SRC_T0]) |-> $past(irq_en_q[ETF_SRC_T0]))
    else $error("timer 0 pending while disabled");
  // R7 timer 1 flag
  chk_t1_flag_set: assert property ( // R7
    tmr_ovf_i[1] |=> flag[ETF_SRC_T1])
    else $error("timer 1 flag missed");
  // R7 timer 1 gate
  chk_t1_vec_gate: assert property ( // R7
    $rose(pend_q[ETF_SRC_T1]) |-> $past(irq_en_q[ETF_SRC_T1]))
    else $error("timer 1 pending while disabled");
  // R8 timer 2 flag
  chk_t2_flag_set: assert property ( // R8
    tmr_ovf_i[2] |=> flag[ETF_SRC_T2])
    else $error("timer 2 flag missed");
  // R8 timer 2 gate
  chk_t2_vec_gate: assert property ( // R8
    $rose(pend_q[ETF_SRC_T2]) |-> $past(irq_en_q[ETF_SRC_T2]))
    else $error("timer 2 pending while disabled");
  // R9 pwm timer flag
  chk_pwm_flag_set: assert property ( // R9
    tmr_ovf_i[3] |=> flag[ETF_SRC_PWM])
    else $error("pwm timer flag missed");
  // R9 pwm timer gate
  chk_pwm_vec_gate: assert property ( // R9
    $rose(pend_q[ETF_SRC_PWM]) |-> $past(irq_en_q[ETF_SRC_PWM]))
    else $error("pwm timer pending while disabled");
  // R10 no late vector
  chk_no_late_vec: assert property ( // R10
    (wr_en && (src_evt == '0) && (pend_q == '0)) |=> (pend_q == '0))
    else $error("enabling a source created a pending vector");
  // R10 clear drops intent
  chk_pend_clear: assert property ( // R10
    (wr_flag && !reg_wdata_i[ETF_SRC_T1] && !tmr_ovf_i[1]) |=> !pend_q[ETF_SRC_T1])
    else $error("cleared flag left a pending vector");
  // R13 enable restored on return
  chk_gie_return: assert property ( // R13
    (return_from_irq_i && !take) |=> global_irq_enable_o ##1 (vec_load_o == $past(take)))
    else $error("return did not restore global enable");
  // R13 vector needs enable
  chk_vec_needs_gie: assert property ( // R13
    vec_load_o |-> $past(global_irq_enable_o))
    else $error("vector taken with global enable off");
  // R14 context saved
  chk_ctx_save: assert property ( // R14
    take |=> buf_valid_q && (ctx_buf_q == $past(ctx_i)))
    else $error("context not saved on entry");
  // R14 context restored
  chk_ctx_restore: assert property ( // R14
    (return_from_irq_i && buf_valid_q) |=> ctx_restore_o && (ctx_o == $past(ctx_buf_q)))
    else $error("context not restored on return");
  // R15 flag held
  chk_flag_hold: assert property ( // R15
    (flag[ETF_SRC_T1] && !wr_flag) |=> flag[ETF_SRC_T1])
    else $error("flag dropped without a clear");
  // R15 written zero clears
  chk_flag_clear: assert property ( // R15
    (wr_flag && !reg_wdata_i[ETF_SRC_T0] && !tmr_ovf_i[0]) |=> !flag[ETF_SRC_T0])
    else $error("written zero did not clear the flag");
endmodule : etf_irq_ctrl
`default_nettype wire

/* File: src/etf_sticky.sv */
`timescale 1ns/1ps
`default_nettype none
module etf_sticky #(
  parameter logic CLR_VAL = 1'b0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // event and software write
  input wire logic set_i,
  input wire logic wr_i,
  input wire logic wbit_i,
  // flag
  output logic q_o
);
  import etf_pkg::*;
  logic q_q;
  logic q_d;
  logic clr;
  assign clr = wr_i && (wbit_i == CLR_VAL);
  // set wins over a clear in the same cycle
  assign q_d = set_i | (q_q & ~clr);
  assign q_o = q_q;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) q_q <= 1'b0;
    else q_q <= q_d;
  end
endmodule : etf_sticky
`default_nettype wire

/* File: verif/etf_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module etf_core_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // bench control: timer launch, cycles from vector to return
  input wire logic [3:0] start_i,
  input wire logic [7:0] ret_wait_i,
  // device side
  input wire logic vec_load_i,
  output logic [3:0] tmr_ovf_o,
  output logic return_from_irq_o,
  output etf_pkg::etf_ctx_t ctx_o
);
  import etf_pkg::*;
  logic [7:0] cnt_q [4];
  logic [7:0] rld_q [4];
  logic [3:0] run_q;
  logic [7:0] wait_q;
  always_ff @(posedge core_clk_i) begin
    tmr_ovf_o <= 4'h0;
    return_from_irq_o <= 1'b0;
    if (rst_i) begin
      run_q <= 4'h0;
      wait_q <= 8'h00;
      ctx_o <= 16'h5ac3;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (start_i[k]) begin
          cnt_q[k] <= 8'hfc;
          rld_q[k] <= 8'hfc;
          run_q[k] <= 1'b1;
        end else if (run_q[k]) begin
          cnt_q[k] <= (cnt_q[k] == 8'hff) ? rld_q[k] : cnt_q[k] + 8'h01;
          if (cnt_q[k] == 8'hff) begin
            tmr_ovf_o[k] <= 1'b1;
            run_q[k] <= 1'b0;
          end
        end
      end
      // service routine alters the work register and status flags in the cycle it returns
      if (vec_load_i) begin
        wait_q <= ret_wait_i;
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
        if (wait_q == 8'h01) begin
          return_from_irq_o <= 1'b1;
          ctx_o <= ctx_o + 16'h0101;
        end
      end
    end
  end
endmodule : etf_core_model
`default_nettype wire

/* File: verif/ext_edge_and_timer_irq_flags_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_edge_and_timer_irq_flags_tb;
  import etf_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic pin = 1'b0;
  logic pwr_dn = 1'b0;
  logic [3:0] start = 4'h0;
  logic [7:0] ret_wait = 8'h06;
  logic [7:0] rdata;
  logic [3:0] ovf;
  logic [11:0] vec_addr;
  logic wake, ret, vec_load, restore, global_irq_enable, irq;
  etf_ctx_t ctx, ctx_back;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_vec = 0;
  int v0;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (vec_load === 1'b1) n_vec++;

  etf_irq_ctrl u_etf_irq_ctrl (.core_clk_i(core_clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .ext_pin_irq_i(pin), .power_down_i(pwr_dn), .wake_o(wake), .tmr_ovf_i(ovf),
    .ctx_i(ctx), .return_from_irq_i(ret), .vec_load_o(vec_load), .vec_addr_o(vec_addr),
    .ctx_o(ctx_back), .ctx_restore_o(restore), .global_irq_enable_o(global_irq_enable), .irq_o(irq));
  etf_core_model u_etf_core_model (.core_clk_i(core_clk), .rst_i(rst), .start_i(start),
    .ret_wait_i(ret_wait), .vec_load_i(vec_load), .tmr_ovf_o(ovf),
    .return_from_irq_o(ret), .ctx_o(ctx));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge core_clk);
    we <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge core_clk);
    re <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, exp});
  endtask : rdc
  task automatic pin_to(input logic v);
    @(posedge core_clk);
    pin <= v;
    repeat (8) @(posedge core_clk);
  endtask : pin_to
  task automatic fire(input int k);
    @(posedge core_clk);
    start <= 4'(1 << k);
    @(posedge core_clk);
    start <= 4'h0;
  endtask : fire
  task automatic wait_hi(input bit sel);
    int n;
    n = 0;
    while ((sel ? restore : vec_load) !== 1'b1 && n < 80) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(16'(n < 80), 16'h0001);
  endtask : wait_hi
  // take a vector, clear the flags inside the routine, check the return
  task automatic serve();
    etf_ctx_t c;
    wait_hi(1'b0);
    c = ctx;
    chk({4'h0, vec_addr}, 16'h0008);
    chk({15'h0, global_irq_enable}, 16'h0000);
    wr(ETF_OFS_IRQ_FLAG, 8'h00);
    rdc(ETF_OFS_STATE, 8'h05);
    wait_hi(1'b1);
    chk(ctx_back, c);
    chk({15'h0, global_irq_enable}, 16'h0001);
    rdc(ETF_OFS_STATE, 8'h00);
  endtask : serve
  task automatic note(input string s);
    $display("test %0s done", s);
  endtask : note
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #40000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rdc(ETF_OFS_EDGE, 8'h00);
    rdc(ETF_OFS_IRQ_EN, 8'h00);
    rdc(ETF_OFS_IRQ_FLAG, 8'h00);
    rdc(ETF_OFS_CTRL, 8'h00);
    rdc(8'h10, 8'h00);
    note("reset");
    wr(ETF_OFS_CTRL, 8'h80);
    for (int k = 0; k < 4; k++) begin
      fire(k);
      repeat (10) @(posedge core_clk);
      rdc(ETF_OFS_IRQ_FLAG, 8'((4 << k) - 2));
    end
    wr(ETF_OFS_IRQ_EN, 8'h1e);
    repeat (10) @(posedge core_clk);
    chk(16'(n_vec), 16'h0000);
    wr(ETF_OFS_IRQ_FLAG, 8'h1e);
    rdc(ETF_OFS_IRQ_FLAG, 8'h1e);
    wr(ETF_OFS_IRQ_FLAG, 8'h00);
    rdc(ETF_OFS_IRQ_FLAG, 8'h00);
    note("disabled timers");
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      ret_wait <= 8'(6 + 20 * k);
      fire(k);
      serve();
    end
    wr(ETF_OFS_CTRL, 8'h00);
    fire(0);
    repeat (12) @(posedge core_clk);
    chk(16'(n_vec), 16'h0004);
    wr(ETF_OFS_IRQ_FLAG, 8'h00);
    note("enabled timers");
    wr(ETF_OFS_IRQ_EN, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(ETF_OFS_EDGE, 8'(s));
      pin_to(1'b1);
      rdc(ETF_OFS_IRQ_FLAG, 8'(s & 1));
      wr(ETF_OFS_IRQ_FLAG, 8'h00);
      pin_to(1'b0);
      rdc(ETF_OFS_IRQ_FLAG, 8'(s >> 1));
      wr(ETF_OFS_IRQ_FLAG, 8'h00);
    end
    wr(ETF_OFS_IRQ_EN, 8'h00);
    pin_to(1'b1);
    rdc(ETF_OFS_IRQ_FLAG, 8'h00);
    pin_to(1'b0);
    wr(ETF_OFS_IRQ_EN, 8'h01);
    wr(ETF_OFS_CTRL, 8'h80);
    @(posedge core_clk);
    pin <= 1'b1;
    serve();
    note("external pin");
    wr(ETF_OFS_EDGE, 8'h01);
    pin_to(1'b0);
    @(posedge core_clk);
    pwr_dn <= 1'b1;
    v0 = n_vec;
    pin_to(1'b1);
    chk({15'h0, wake}, 16'h0001);
    chk(16'(n_vec - v0), 16'h0000);
    @(posedge core_clk);
    pwr_dn <= 1'b0;
    serve();
    chk({15'h0, irq}, 16'h0000);
    wr(ETF_OFS_EVT_MASK, 8'h02);
    #1 chk({15'h0, irq}, 16'h0001);
    wr(ETF_OFS_EVT_STAT, 8'h02);
    #1 chk({15'h0, irq}, 16'h0000);
    rdc(ETF_OFS_EVT_STAT, 8'h05);
    note("wake and status");
    complete_run();
  end
endmodule : ext_edge_and_timer_irq_flags_tb
`default_nettype wire
